// >>> hdl/flow_pkg.sv
// Purpose: Shared constants for the program-flow and status control block.
// Assumes: 250 MHz system clock, register port with one-cycle read latency.
// Notes:   Register indices are word offsets on the plain register port.
package flow_pkg;
  localparam int unsigned PC_W          = 10;
  localparam int unsigned STK_DEPTH     = 5;
  localparam int unsigned NUM_IRQ       = 5;
  localparam int unsigned CFG_W         = 14;
  localparam logic [9:0]  RESET_VEC     = 10'h000;
  localparam logic [9:0]  IRQ_VEC       = 10'h001;
  localparam logic [9:0]  CFG_ADDR      = 10'h3fc;
  localparam logic [13:0] CFG_ERASED    = 14'h3fff;
  // Config word fields
  localparam int unsigned CFG_GUARD_N   = 13;
  localparam int unsigned CFG_HALF_N    = 12;
  localparam int unsigned CFG_BROWNOUT  = 11;
  localparam int unsigned CFG_CLOCK_SOURCE_SEL_LO   = 8;
  localparam int unsigned CFG_PIN_RST   = 7;
  localparam int unsigned CFG_WDT_RST   = 6;
  localparam int unsigned CFG_OSC_FREQ  = 5;
  // Status register fields
  localparam int unsigned ST_TIMEOUT    = 4;
  localparam int unsigned ST_SLEEP      = 3;
  localparam int unsigned ST_ZERO       = 2;
  localparam int unsigned ST_HALF       = 1;
  localparam int unsigned ST_CARRY      = 0;
  localparam logic [7:0]  STATUS_RST    = 8'h00;
  // Register port map
  localparam logic [3:0]  REG_STATUS    = 4'h0;
  localparam logic [3:0]  REG_IRQ_PEND  = 4'h1;
  localparam logic [3:0]  REG_IRQ_EN    = 4'h2;
  localparam logic [3:0]  REG_PC_LO     = 4'h3;
  localparam logic [3:0]  REG_PC_HI     = 4'h4;
  localparam logic [3:0]  REG_ACC       = 4'h5;
  localparam logic [3:0]  REG_CFG_LO    = 4'h6;
  localparam logic [3:0]  REG_CFG_HI    = 4'h7;
  localparam logic [3:0]  REG_FLOW      = 4'h8;
  // Instruction operation codes presented by the external decoder
  typedef enum logic [3:0] {
    OP_NEXT   = 4'h0,
    OP_JUMP   = 4'h1,
    OP_CALL   = 4'h2,
    OP_RET    = 4'h3,
    OP_RETURN_FROM_INTERRUPT   = 4'h4,
    OP_RETLIT = 4'h5,
    OP_PCLO   = 4'h6,
    OP_ALU    = 4'h7,
    OP_CLEAR_WATCHDOG_INSTRUCTION = 4'h8,
    OP_SLEEP  = 4'h9
  } flow_op_t;
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_OR  = 3'h3,
    ALU_XOR = 3'h4,
    ALU_SHL = 3'h5,
    ALU_SHR = 3'h6,
    ALU_MOV = 3'h7
  } alu_op_t;
  typedef enum logic [1:0] {
    ST_LOADCFG = 2'b00,
    ST_RUN     = 2'b01,
    ST_FLUSH   = 2'b10
  } core_state_t;
endpackage

// >>> hdl/cpu_flow_status_irq_reset.sv
// Purpose: Program counter, return stack, flags, status, interrupt entry
//          and reset handling for a small 8-bit core.
// Assumes: Instruction decode is outside; it presents op codes one per
//          instruction cycle and reads exec_strobe to know when to apply.
// Notes:   One instruction cycle is two sys_clk phases.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Ten-bit program counter addresses 1K words and normally increments.
// - Reset starts at address zero; interrupt entry goes to address one.
// - Call and jump load the full ten-bit target from the instruction.
// - Return, interrupt return and literal return pop the stack top.
// - Other writes of the low eight bits keep the upper two bits.
// - Return stack holds five ten-bit entries.
// - Call and interrupt entry push the return address, last in first out.
// - Eight-bit ALU with add, subtract, shifts, logic and an accumulator.
// - Subtract carry and half carry hold inverted borrows.
// - ALU writes to status flags are suppressed when the op sets flags; computed flags win.
// - Timeout flag cleared by power-on, brownout, clear-watchdog, sleep.
// - Sleep flag cleared by power-on, brownout, clear-watchdog; sleep sets.
// - Five sources, one vector, one level, per-source enables, no priority.
// - Events set pending flags regardless of enable.
// - Enabled pending source taken at cycle end; call to one, in-service set.
// - In-service clears in the instruction after interrupt return.
// - Requests are levels on pending flags; service code clears them.
// - Power-on reset restores defaults; config word then selects modes.
// - Pin reset, if enabled, keeps timeout and sleep; watchdog reset keeps sleep, sets timeout.
// - Fourteen-bit config word at 3FCh, erased value 3FFFh, read only.
// - Config bit 13 low blocks programming-tool readback.
// - Config bit 6 high: watchdog overflow resets, else wake-timer event.
// - Instruction cycle is two halves; PC updates first, fetch latches second.
// - Branches take two cycles because the fetched word is flushed.
module cpu_flow_status_irq_reset
  import flow_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Reset sources (rst is power-on; the others are synchronous levels)
  input  wire logic        brownout_reset,
  input  wire logic        pin_reset_n,
  input  wire logic        watchdog_overflow,
  // Program memory
  output logic [9:0]       pmem_addr,
  output logic             pmem_rd,
  input  wire logic [13:0] pmem_data,
  output logic [13:0]      instr_ff,
  // Instruction stream from the decoder
  input  wire logic [3:0]  op,
  input  wire logic [9:0]  op_target,
  input  wire logic [7:0]  op_pclo,
  input  wire logic [2:0]  alu_op,
  input  wire logic [7:0]  alu_operand,
  input  wire logic        alu_to_acc,
  input  wire logic        alu_dest_status,
  input  wire logic        alu_sets_flags,
  output logic             exec_strobe,
  output logic [7:0]       alu_result_ff,
  // Interrupt sources
  input  wire logic [4:0]  irq_event,
  output logic             in_service,
  // Decoded configuration and reset outputs
  output logic [13:0]      config_word,
  output logic             readout_guard_n,
  output logic             second_half_mode_n,
  output logic [1:0]      clock_source_sel,
  output logic             wake_timer_irq,
  output logic             core_reset,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata
);

  core_state_t      state_ff;
  logic             phase_ff;
  logic [9:0]       pc_ff;
  logic [9:0]       stack_ff [STK_DEPTH];
  logic [2:0]       sp_ff;
  logic [7:0]       acc_ff;
  logic [7:0]       status_ff;
  logic [4:0]       pend_ff;
  logic [4:0]       irq_en_ff;
  logic             isr_ff;
  logic             isr_clr_ff;
  logic [13:0]      cfg_ff;
  logic [1:0]       cfg_step_ff;
  logic             flush_arm_ff;
  logic [7:0]       rdata_ff;
  logic             phase_one;
  logic             phase_two;
  logic             soft_rst;
  logic             take_irq;
  logic [9:0]       nxt_pc;
  logic             branch;
  logic [8:0]       sum9;
  logic [4:0]       low5;
  logic [7:0]       alu_res;
  logic             alu_c;
  logic             alu_dc;
  logic             exec;

  assign phase_one = (phase_ff == 1'b0);
  assign phase_two = (phase_ff == 1'b1);
  // Pin reset and watchdog reset only act when the config word enables them
  assign soft_rst = (!pin_reset_n && cfg_ff[CFG_PIN_RST]) ||
                    (watchdog_overflow && cfg_ff[CFG_WDT_RST]);
  assign exec = (state_ff == ST_RUN) && phase_one;
  assign exec_strobe = exec;
  assign take_irq = exec && !isr_ff && |(pend_ff & irq_en_ff);
  assign branch = take_irq ||
                  (flow_op_t'(op) inside {OP_JUMP, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT,
                                          OP_RETLIT, OP_PCLO});

  // Config word decode
  assign config_word        = cfg_ff;
  assign readout_guard_n    = cfg_ff[CFG_GUARD_N];
  assign second_half_mode_n = cfg_ff[CFG_HALF_N];
  assign clock_source_sel   = cfg_ff[CFG_CLOCK_SOURCE_SEL_LO+1:CFG_CLOCK_SOURCE_SEL_LO];
  assign wake_timer_irq     = watchdog_overflow && !cfg_ff[CFG_WDT_RST];
  assign core_reset         = soft_rst;
  assign in_service         = isr_ff;
  assign reg_rdata          = rdata_ff;
  assign pmem_addr = (state_ff == ST_LOADCFG) ? CFG_ADDR : pc_ff;
  assign pmem_rd   = (state_ff == ST_LOADCFG) || phase_two;

  // Next program counter
  always_comb begin
    nxt_pc = pc_ff + 10'h001;
    if (take_irq) begin
      nxt_pc = IRQ_VEC;
    end else begin
      unique case (flow_op_t'(op))
        OP_JUMP, OP_CALL: nxt_pc = op_target;
        OP_RET, OP_RETURN_FROM_INTERRUPT, OP_RETLIT:
          nxt_pc = stack_ff[(sp_ff == 3'd0) ? 3'(STK_DEPTH - 1)
                                             : sp_ff - 3'd1];
        OP_PCLO: nxt_pc = {pc_ff[9:8], op_pclo};
        default: nxt_pc = pc_ff + 10'h001;
      endcase
    end
  end

  // ALU datapath; subtraction flags are inverted borrows
  always_comb begin
    sum9    = 9'h000;
    low5    = 5'h00;
    alu_res = 8'h00;
    alu_c   = status_ff[ST_CARRY];
    alu_dc  = status_ff[ST_HALF];
    unique case (alu_op_t'(alu_op))
      ALU_ADD: begin
        sum9    = {1'b0, acc_ff} + {1'b0, alu_operand};
        low5    = {1'b0, acc_ff[3:0]} + {1'b0, alu_operand[3:0]};
        alu_res = sum9[7:0];
        alu_c   = sum9[8];
        alu_dc  = low5[4];
      end
      ALU_SUB: begin
        sum9    = {1'b0, alu_operand} - {1'b0, acc_ff};
        low5    = {1'b0, alu_operand[3:0]} - {1'b0, acc_ff[3:0]};
        alu_res = sum9[7:0];
        alu_c   = !sum9[8];
        alu_dc  = !low5[4];
      end
      ALU_AND: alu_res = acc_ff & alu_operand;
      ALU_OR:  alu_res = acc_ff | alu_operand;
      ALU_XOR: alu_res = acc_ff ^ alu_operand;
      ALU_SHL: begin
        alu_res = {alu_operand[6:0], status_ff[ST_CARRY]};
        alu_c   = alu_operand[7];
      end
      ALU_SHR: begin
        alu_res = {status_ff[ST_CARRY], alu_operand[7:1]};
        alu_c   = alu_operand[0];
      end
      ALU_MOV: alu_res = alu_operand;
    endcase
  end

  // Sequencer: config load, two-phase run, flush after branches
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff    <= ST_LOADCFG;
      phase_ff    <= 1'b0;
      cfg_step_ff <= 2'b00;
      flush_arm_ff <= 1'b0;
    end else if (brownout_reset || soft_rst) begin
      state_ff    <= ST_LOADCFG;
      phase_ff    <= 1'b0;
      cfg_step_ff <= 2'b00;
    end else begin
      unique case (state_ff)
        ST_LOADCFG: begin
          // Memory answers one cycle after the address; wait it out
          cfg_step_ff <= cfg_step_ff + 2'b01;
          if (cfg_step_ff == 2'b01) begin
            state_ff <= ST_FLUSH;
          end
        end
        ST_RUN: begin
          phase_ff <= !phase_ff;
          if (exec && branch) begin
            state_ff <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          // Whole refill cycle: both halves must pass before the next execute
          phase_ff <= !phase_ff;
          flush_arm_ff <= phase_one;
          if (phase_two && flush_arm_ff) begin
            state_ff <= ST_RUN;
          end
        end
        default: state_ff <= ST_LOADCFG;
      endcase
    end
  end

  // Config latch, captured only while the core is held
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= CFG_ERASED;
    end else if (state_ff == ST_LOADCFG && cfg_step_ff == 2'b01) begin
      cfg_ff <= pmem_data;
    end
  end

  // Fetch latch in second phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      instr_ff <= 14'h0000;
    end else if (state_ff != ST_LOADCFG && phase_two) begin
      instr_ff <= pmem_data;
    end
  end

  // Program counter, updated in the first phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_ff <= RESET_VEC;
    end else if (brownout_reset || soft_rst || state_ff == ST_LOADCFG) begin
      pc_ff <= RESET_VEC;
    end else if (exec) begin
      pc_ff <= nxt_pc;
    end
  end

  // Return stack; pushes past five wrap over the oldest entry
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sp_ff <= 3'd0;
      for (int i = 0; i < STK_DEPTH; i++) begin
        stack_ff[i] <= 10'h000;
      end
    end else if (brownout_reset || soft_rst) begin
      sp_ff <= 3'd0;
    end else if (exec) begin
      if (take_irq || flow_op_t'(op) == OP_CALL) begin
        // Interrupt pushes the address of the instruction it displaced
        stack_ff[sp_ff] <= take_irq ? pc_ff : pc_ff + 10'h001;
        sp_ff <= (sp_ff == 3'(STK_DEPTH - 1)) ? 3'd0 : sp_ff + 3'd1;
      end else if (flow_op_t'(op) inside {OP_RET, OP_RETURN_FROM_INTERRUPT, OP_RETLIT}) begin
        sp_ff <= (sp_ff == 3'd0) ? 3'(STK_DEPTH - 1) : sp_ff - 3'd1;
      end
    end
  end

  // Accumulator and result register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_ff        <= 8'h00;
      alu_result_ff <= 8'h00;
    end else if (brownout_reset || soft_rst) begin
      acc_ff        <= 8'h00;
      alu_result_ff <= 8'h00;
    end else if (exec && !take_irq && flow_op_t'(op) == OP_ALU) begin
      alu_result_ff <= alu_res;
      if (alu_to_acc) begin
        acc_ff <= alu_res;
      end
    end else if (reg_wr && reg_addr == REG_ACC) begin
      acc_ff <= reg_wdata;
    end
  end

  // Status: arithmetic flags and reset-cause flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_ff <= STATUS_RST;
    end else if (brownout_reset) begin
      status_ff <= STATUS_RST;
    end else if (soft_rst) begin
      // Cause flags survive; timeout records a watchdog reset
      status_ff[2:0] <= 3'b000;
      if (watchdog_overflow) begin
        status_ff[ST_TIMEOUT] <= 1'b1;
      end
    end else begin
      if (watchdog_overflow) begin
        status_ff[ST_TIMEOUT] <= 1'b1;
      end else if (exec && !take_irq &&
                   flow_op_t'(op) inside {OP_CLEAR_WATCHDOG_INSTRUCTION, OP_SLEEP}) begin
        status_ff[ST_TIMEOUT] <= 1'b0;
      end
      if (exec && !take_irq && flow_op_t'(op) == OP_SLEEP) begin
        status_ff[ST_SLEEP] <= 1'b1;
      end else if (exec && !take_irq && flow_op_t'(op) == OP_CLEAR_WATCHDOG_INSTRUCTION) begin
        status_ff[ST_SLEEP] <= 1'b0;
      end
      if (exec && !take_irq && flow_op_t'(op) == OP_ALU) begin
        if (alu_sets_flags) begin
          // Computed flags override any result aimed at status
          status_ff[ST_ZERO]  <= (alu_res == 8'h00);
          status_ff[ST_HALF]  <= alu_dc;
          status_ff[ST_CARRY] <= alu_c;
        end else if (alu_dest_status) begin
          status_ff[2:0] <= alu_res[2:0];
        end
      end else if (reg_wr && reg_addr == REG_STATUS) begin
        status_ff[2:0] <= reg_wdata[2:0];
      end
    end
  end

  // Pending flags: events set regardless of enable, set beats clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_ff <= 5'h00;
    end else if (brownout_reset || soft_rst) begin
      pend_ff <= 5'h00;
    end else if (reg_wr && reg_addr == REG_IRQ_PEND) begin
      pend_ff <= (pend_ff & reg_wdata[4:0]) | irq_event;
    end else begin
      pend_ff <= pend_ff | irq_event;
    end
  end

  // Enable register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_en_ff <= 5'h00;
    end else if (brownout_reset || soft_rst) begin
      irq_en_ff <= 5'h00;
    end else if (reg_wr && reg_addr == REG_IRQ_EN) begin
      irq_en_ff <= reg_wdata[4:0];
    end
  end

  // In-service flag; clear is delayed one instruction after return
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      isr_ff     <= 1'b0;
      isr_clr_ff <= 1'b0;
    end else if (brownout_reset || soft_rst) begin
      isr_ff     <= 1'b0;
      isr_clr_ff <= 1'b0;
    end else if (take_irq) begin
      isr_ff     <= 1'b1;
      isr_clr_ff <= 1'b0;
    end else if (exec) begin
      if (isr_clr_ff) begin
        isr_ff     <= 1'b0;
        isr_clr_ff <= 1'b0;
      end else if (flow_op_t'(op) == OP_RETURN_FROM_INTERRUPT) begin
        isr_clr_ff <= 1'b1;
      end
    end
  end

  // Register read port, data valid the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS:   rdata_ff <= {3'b000, status_ff[4:0]};
        REG_IRQ_PEND: rdata_ff <= {3'b000, pend_ff};
        REG_IRQ_EN:   rdata_ff <= {3'b000, irq_en_ff};
        REG_PC_LO:    rdata_ff <= pc_ff[7:0];
        REG_PC_HI:    rdata_ff <= {6'h00, pc_ff[9:8]};
        REG_ACC:      rdata_ff <= acc_ff;
        REG_CFG_LO:   rdata_ff <= cfg_ff[7:0];
        REG_CFG_HI:   rdata_ff <= {2'b00, cfg_ff[13:8]};
        REG_FLOW:     rdata_ff <= {4'h0, sp_ff, isr_ff};
        default:      rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// >>> verification/pmem_model.sv
// Purpose: Program memory seen from the fetch port of the flow block.
// Assumes: Data answers within the read cycle, as the core latches it then.
// Notes:   Word at the config address is a parameter; others echo address.
`timescale 1ns/1ns
`default_nettype none
module pmem_model
  import flow_pkg::*;
#(
  parameter logic [13:0] CFG = 14'h1f9f
)(
  // Fetch port
  input  wire logic [9:0]  pmem_addr,
  input  wire logic        pmem_rd,
  output var  logic [13:0] pmem_data
);
  logic [13:0] word;
  // Idle bus shows the inverse so a stale word is never mistaken for data
  always_comb begin
    word      = (pmem_addr == CFG_ADDR) ? CFG : {4'h0, pmem_addr};
    pmem_data = pmem_rd ? word : ~word;
  end
endmodule
`default_nettype wire

// >>> verification/flow_chk.sv
// Purpose: Port-level checks for the program-flow block.
// Assumes: One sys_clk domain; soft resets restart the pipeline.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module flow_chk
  import flow_pkg::*;
(
  // Clock and resets
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        brownout_reset,
  input wire logic        core_reset,
  // Fetch and execute
  input wire logic [9:0]  pmem_addr,
  input wire logic        pmem_rd,
  input wire logic [3:0]  op,
  input wire logic [9:0]  op_target,
  input wire logic        exec_strobe,
  input wire logic        in_service,
  // Configuration
  input wire logic        watchdog_overflow,
  input wire logic [13:0] config_word,
  input wire logic        readout_guard_n,
  input wire logic        wake_timer_irq
);
  // Soft resets abort checks, since the pipeline restarts under them
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst || core_reset || brownout_reset);

  sequence s_branch;
    exec_strobe && op inside {[4'h1:4'h6]};
  endsequence
  sequence s_flush;
    !exec_strobe [*3];
  endsequence
  property p_load;
    $fell(rst) |-> pmem_addr == CFG_ADDR && pmem_rd && !exec_strobe;
  endproperty
  property p_flush;
    s_branch |=> s_flush ##1 exec_strobe;
  endproperty
  property p_strobe;
    exec_strobe |=> !exec_strobe;
  endproperty
  property p_jump;
    exec_strobe && op == OP_JUMP && !core_reset && !brownout_reset
      |=> $rose(in_service) || pmem_addr == $past(op_target);
  endproperty
  property p_next;
    exec_strobe && op == OP_NEXT && !core_reset && !brownout_reset
      |=> $rose(in_service) || pmem_addr == $past(pmem_addr) + 10'h1;
  endproperty
  property p_irq;
    $rose(in_service) |-> $past(exec_strobe) && pmem_addr == IRQ_VEC;
  endproperty
  property p_wake;
    wake_timer_irq == (watchdog_overflow && !config_word[CFG_WDT_RST]);
  endproperty
  property p_guard;
    readout_guard_n == config_word[CFG_GUARD_N];
  endproperty

  a_load: assert property (p_load)
    else $error("config load step wrong");
  a_flush: assert property (p_flush)
    else $error("branch flush length wrong");
  a_strobe: assert property (p_strobe)
    else $error("execute strobe in two cycles running");
  a_jump: assert property (p_jump)
    else $error("jump target not loaded");
  a_next: assert property (p_next)
    else $error("counter did not advance by one");
  a_irq: assert property (p_irq)
    else $error("interrupt entry not at vector");
  a_wake: assert property (p_wake)
    else $error("wake timer request wrong");
  a_guard: assert property (p_guard)
    else $error("readout guard wrong");
endmodule

bind cpu_flow_status_irq_reset flow_chk u_flow_chk (
  .sys_clk, .rst, .brownout_reset, .core_reset, .pmem_addr, .pmem_rd, .op,
  .op_target, .exec_strobe, .in_service, .watchdog_overflow, .config_word,
  .readout_guard_n, .wake_timer_irq
);
`default_nettype wire

// >>> verification/test_cpu_flow_status_irq_reset.sv
// Purpose: Self-checking bench for the program-flow block.
// Assumes: Ops applied at exec_strobe edges; register port one-cycle read.
// Notes:   A small stack model predicts every program counter value.
`timescale 1ns/1ns
`default_nettype none
module test_cpu_flow_status_irq_reset;
  import flow_pkg::*;
  localparam logic [13:0] CFG = 14'h1f9f;
  localparam logic [2:0] ACT [8] = '{0, 1, 2, 0, 1, 3, 1, 4};
  localparam logic [7:0] EXS [8] = '{8'h0d, 8'h1d, 8'h18, 8'h08,
                                     8'h18, 8'h00, 8'h10, 8'h00};
  // Design inputs, all given a value at time zero
  logic        sys_clk = 0, rst = 1, brownout_reset = 0, pin_reset_n = 1;
  logic        watchdog_overflow = 0, reg_wr = 0, reg_rd = 0;
  logic        alu_to_acc = 0, alu_dest_status = 0, alu_sets_flags = 0;
  logic [3:0]  op = 0, reg_addr = 0;
  logic [9:0]  op_target = 0;
  logic [7:0]  op_pclo = 0, alu_operand = 0, reg_wdata = 0;
  logic [2:0]  alu_op = 0;
  logic [4:0]  irq_event = 0;
  // Design outputs
  logic [9:0]  pmem_addr;
  logic [13:0] pmem_data, instr_ff, config_word;
  logic [7:0]  alu_result_ff, reg_rdata, rd;
  logic [1:0]  clock_source_sel;
  logic        pmem_rd, exec_strobe, in_service, readout_guard_n;
  logic        second_half_mode_n, wake_timer_irq, core_reset;
  int          mismatches = 0;
  int          n_checks = 0;
  logic [9:0]  stk [$];

  always #2 sys_clk = ~sys_clk;

  cpu_flow_status_irq_reset DUT (.*);
  pmem_model #(.CFG(CFG)) u_mem (.pmem_addr(pmem_addr),
    .pmem_rd(pmem_rd), .pmem_data(pmem_data));

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdreg(logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // Holds an op until an execute edge takes it; take marks interrupt entry
  task automatic run_op(logic [3:0] o, logic [9:0] t, logic [7:0] lo, bit take);
    logic [9:0] pc0, exp;
    int n;
    @(posedge sys_clk);
    op <= o;
    op_target <= t;
    op_pclo <= lo;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (exec_strobe !== 1'b1 && n < 50);
    pc0 = pmem_addr;
    check("fetch", instr_ff, {4'h0, pc0});
    @(posedge sys_clk);
    op <= OP_NEXT;
    if (take) begin
      stk.push_back(pc0);
      exp = IRQ_VEC;
    end else begin
      case (o)
        OP_JUMP: exp = t;
        OP_CALL: begin
          stk.push_back(pc0 + 10'h1);
          exp = t;
        end
        OP_RET, OP_RETURN_FROM_INTERRUPT, OP_RETLIT: exp = stk.pop_back();
        OP_PCLO: exp = {pc0[9:8], lo};
        default: exp = pc0 + 10'h1;
      endcase
    end
    #1 check("pc", pmem_addr, exp);
  endtask

  task automatic alu(logic [2:0] a, logic [7:0] w, logic [7:0] b, logic d,
                     logic [7:0] r, logic [2:0] f, logic [2:0] m);
    wr(REG_ACC, w);
    alu_op <= a;
    alu_operand <= b;
    alu_dest_status <= d;
    alu_to_acc <= !d;
    alu_sets_flags <= 1'b1;
    run_op(OP_ALU, 0, 0, 0);
    alu_sets_flags <= 1'b0;
    alu_to_acc <= 1'b0;
    alu_dest_status <= 1'b0;
    check("alu", alu_result_ff, r);
    rdreg(REG_STATUS);
    check("flags", rd[2:0] & m, f & m);
    if (!d) begin
      rdreg(REG_ACC);
      check("acc", rd, r);
    end
  endtask

  task automatic irq(logic [4:0] m);
    @(posedge sys_clk);
    irq_event <= m;
    @(posedge sys_clk);
    irq_event <= 5'h00;
  endtask

  // Watchdog: cuts a hang well past the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    run_op(OP_JUMP, 10'h2f0, 0, 0);
    run_op(OP_CALL, 10'h155, 0, 0);
    run_op(OP_NEXT, 0, 0, 0);
    run_op(OP_CALL, 10'h300, 0, 0);
    run_op(OP_RET, 0, 0, 0);
    run_op(OP_RETLIT, 0, 0, 0);
    run_op(OP_PCLO, 0, 8'h22, 0);
    run_op(OP_JUMP, 10'h3ff, 0, 0);
    run_op(OP_NEXT, 0, 0, 0);
    for (int i = 0; i < 5; i++) run_op(OP_CALL, 10'(64 * i + 9), 0, 0);
    for (int i = 0; i < 5; i++) run_op(OP_RET, 0, 0, 0);
    rdreg(REG_CFG_LO);
    check("cfg_lo", rd, CFG[7:0]);
    rdreg(REG_CFG_HI);
    check("cfg_hi", rd, {2'b00, CFG[13:8]});
    check("guard", readout_guard_n, CFG[13]);
    check("clock_source_sel", clock_source_sel, CFG[9:8]);
    check("half", second_half_mode_n, CFG[12]);
    check("cfg_word", config_word, CFG);
    rdreg(REG_STATUS);
    check("status", rd, STATUS_RST);
    wr(REG_STATUS, 8'hff);
    rdreg(REG_STATUS);
    check("status_wr", rd, 8'h07);
    rdreg(4'hf);
    check("unmapped", rd, 8'h00);
    alu(ALU_ADD, 8'hf8, 8'h08, 0, 8'h00, 3'b111, 3'b111);
    alu(ALU_SUB, 8'h05, 8'h03, 0, 8'hfe, 3'b000, 3'b111);
    alu(ALU_SUB, 8'h12, 8'h35, 0, 8'h23, 3'b011, 3'b111);
    alu(ALU_AND, 8'h0f, 8'hf0, 0, 8'h00, 3'b100, 3'b100);
    alu(ALU_OR, 8'h01, 8'h80, 0, 8'h81, 3'b000, 3'b100);
    alu(ALU_XOR, 8'h5a, 8'h5a, 0, 8'h00, 3'b100, 3'b100);
    wr(REG_STATUS, 8'h00);
    alu(ALU_ADD, 8'hf8, 8'h08, 1, 8'h00, 3'b111, 3'b111);
    // Cause flags through sleep, watchdog wake event, pin and brownout resets and clear
    wr(REG_STATUS, 8'h05);
    for (int i = 0; i < 8; i++) begin
      case (ACT[i])
        0: run_op(OP_SLEEP, 0, 0, 0);
        4: run_op(OP_CLEAR_WATCHDOG_INSTRUCTION, 0, 0, 0);
        default: begin
          @(posedge sys_clk);
          watchdog_overflow <= (ACT[i] == 1);
          pin_reset_n <= (ACT[i] != 2);
          brownout_reset <= (ACT[i] == 3);
          @(negedge sys_clk);
          if (ACT[i] == 1) check("wake", wake_timer_irq, 1'b1);
          check("core_reset", core_reset, ACT[i] == 2);
          @(posedge sys_clk);
          watchdog_overflow <= 1'b0;
          pin_reset_n <= 1'b1;
          brownout_reset <= 1'b0;
          if (ACT[i] != 1) stk.delete();
        end
      endcase
      rdreg(REG_STATUS);
      check("status_flags", rd, EXS[i]);
    end
    // Pending flags set while disabled, then each source alone
    wr(REG_IRQ_EN, 8'h00);
    irq(5'h1f);
    rdreg(REG_IRQ_PEND);
    check("pend", rd, 8'h1f);
    run_op(OP_NEXT, 0, 0, 0);
    wr(REG_IRQ_PEND, 8'h00);
    rdreg(REG_IRQ_PEND);
    check("pend_clr", rd, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(REG_IRQ_EN, 8'h01 << i);
      irq(5'h01 << i);
      run_op(OP_NEXT, 0, 0, 1);
      check("busy", in_service, 1'b1);
      run_op(OP_NEXT, 0, 0, 0);
      wr(REG_IRQ_PEND, 8'h00);
      run_op(OP_RETURN_FROM_INTERRUPT, 0, 0, 0);
      run_op(OP_NEXT, 0, 0, 0);
      check("idle", in_service, 1'b0);
    end
    // Uncleared request recurs only after one main-line instruction
    wr(REG_IRQ_EN, 8'h01);
    irq(5'h01);
    run_op(OP_NEXT, 0, 0, 1);
    run_op(OP_RETURN_FROM_INTERRUPT, 0, 0, 0);
    check("busy_return_from_interrupt", in_service, 1'b1);
    run_op(OP_NEXT, 0, 0, 0);
    run_op(OP_NEXT, 0, 0, 1);
    wr(REG_IRQ_PEND, 8'h00);
    run_op(OP_RETURN_FROM_INTERRUPT, 0, 0, 0);
    run_op(OP_NEXT, 0, 0, 0);
    summarize();
  end
endmodule
`default_nettype wire
